//--- rtl/sipd_regs.svh
// constants for the state invalidate / prefetch decoder
// assumes: included by bare name from rtl files
`ifndef SIPD_REGS_SVH
`define SIPD_REGS_SVH
// command header fields
`define SIPD_TYPE_HI      31
`define SIPD_TYPE_LO      29
`define SIPD_SUB_HI       28
`define SIPD_SUB_LO       27
`define SIPD_OPC_HI       26
`define SIPD_OPC_LO       24
`define SIPD_SOPC_HI      23
`define SIPD_SOPC_LO      16
`define SIPD_LEN_HI       7
`define SIPD_LEN_LO       0
`define SIPD_ADDR_HI      31
`define SIPD_ADDR_LO      6
`define SIPD_CNT_HI       2
`define SIPD_CNT_LO       0
`define SIPD_INV_PIPE_BIT 2
`define SIPD_INV_CONST_BIT 1
`define SIPD_INV_MEDIA_BIT 0
// field values
`define SIPD_TYPE_GFX     3'h3
`define SIPD_SUB_ONE_DW   2'h1
`define SIPD_SUB_SHARED   2'h0
`define SIPD_OPC_ORDERED  3'h0
`define SIPD_SOPC_INVAL   8'h02
`define SIPD_SOPC_PREF    8'h03
`define SIPD_LINE_BYTES   64
// register offsets (byte addresses, word index = addr[4:2])
`define SIPD_REG_CMD      3'h0
`define SIPD_REG_VALID    3'h1
`define SIPD_REG_SETUP    3'h2
`define SIPD_REG_STATUS   3'h3
`define SIPD_REG_LASTADDR 3'h4
// reset values
`define SIPD_VALID_RST    3'h0
`endif

//--- rtl/sipd_pkg.sv
// types for the state invalidate / prefetch decoder
// assumes: compiled before all rtl modules
package sipd_pkg;
  typedef enum logic [1:0] {
    SIPD_IDLE = 2'b00,
    SIPD_DW1  = 2'b01,
    SIPD_SKIP = 2'b10,
    SIPD_ISSUE = 2'b11
  } sipd_state_e;
  typedef logic [25:0] sipd_line_t;
endpackage

//--- rtl/sipd_valid_flags.sv
// one valid flag per pointer group, cleared by invalidate, set by setup
// assumes: setup and invalidate are one-cycle pulses on mclk
`timescale 1ns/1ps
`include "sipd_regs.svh"
module sipd_valid_flags #(
  parameter int GROUPS = 3
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // events
  input  wire logic [GROUPS-1:0] setup_pulse,
  input  wire logic [GROUPS-1:0] inval_pulse,
  // state
  output logic      [GROUPS-1:0] valid
);
  typedef struct packed { logic [GROUPS-1:0] v; } sipdv_s;
  sipdv_s q, d;
  // per group: a later setup sets, invalidate clears, clear enable leaves alone
  always_comb begin
    d = q;
    for (int i = 0; i < GROUPS; i++) begin
      if (setup_pulse[i]) begin
        d.v[i] = 1'b1;
      end else if (inval_pulse[i]) begin
        d.v[i] = 1'b0;
      end
    end
  end
  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q.v <= GROUPS'(`SIPD_VALID_RST);
    end else begin
      q <= d;
    end
  end
  assign valid = q.v;
  // a cleared enable never drops a flag
  a_flag_kept: assert property (@(posedge mclk) disable iff (!resetn)
    (!inval_pulse[0] && !setup_pulse[0]) |=> valid[0] == $past(valid[0]))
    else $error("group 0 flag changed without cause");
endmodule // sipd_valid_flags

//--- rtl/sipd_line_issuer.sv
// issues consecutive 64-byte line reads for a prefetch
// assumes: memory side may stall with mem_ready low
`timescale 1ns/1ps
`include "sipd_regs.svh"
module sipd_line_issuer (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // start request
  input  wire logic                start,
  input  wire sipd_pkg::sipd_line_t start_line,
  input  wire logic [2:0]          count_m1,
  input  wire logic                abort,
  output logic                     busy,
  // memory read request
  output logic                     mem_read,
  output logic [31:0]              mem_address,
  input  wire logic                mem_ready
);
  typedef struct packed {
    logic                 busy;
    sipd_pkg::sipd_line_t line;
    logic [2:0]           left;
  } sipdl_s;
  sipdl_s q, d;
  // load, then step one line per accepted read, ascending
  always_comb begin
    d = q;
    if (!q.busy) begin
      if (start) begin
        d.busy = 1'b1;
        d.line = start_line;
        d.left = count_m1;
      end
    end else if (abort) begin
      d.busy = 1'b0;
    end else if (mem_ready) begin
      d.line = q.line + 26'h1;
      d.left = q.left - 3'h1;
      if (q.left == 3'h0) begin
        d.busy = 1'b0;
      end
    end
  end
  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign busy        = q.busy;
  assign mem_read    = q.busy && !abort;
  assign mem_address = {q.line, 6'h00};
  // a read's address steps by one line after acceptance
  a_addr_step: assert property (@(posedge mclk) disable iff (!resetn)
    (mem_read && mem_ready && q.left != 3'h0) |=> mem_address == $past(mem_address) + 32'h40)
    else $error("line address did not advance by 64");
endmodule // sipd_line_issuer

//--- rtl/sipd_decoder.sv
// state invalidate / prefetch command decoder top
// assumes: one mclk, synchronous active-low reset, Avalon-MM register slave
// Behaviour
// - invalidate: type 3h, opcode 0h, sub-opcode 02h in dword 0
// - invalidate carries subtype 1h: one dword, no length field
// - bit 2 invalidates pipeline state setup pointers
// - bit 1 invalidates constant block pointer
// - bit 0 invalidates media setup pointers
// - clear enable bit leaves group and its validity unchanged
// - invalid group stops prefetching through it until new setup; the code stops prefetching only when all three groups are invalid
// - prefetch: type 3h, subtype 0h, opcode 0h, sub-opcode 03h
// - opcode 0h is ordered class; processed in stream order
// - prefetch length field is total dwords minus two, default 0h
// - second dword bits 31:6 are 64-byte aligned start address
// - start address used as absolute virtual address, no base added
// - bits 2:0 are line count minus one, 1 to 8 lines
// - device loads consecutive 64-byte lines into state cache
// - prefetch is a hint; may be skipped or cut short
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sipd_regs.svh"
module sipd_decoder (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // command stream
  input  wire logic [31:0] cmd_data,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  // setup commands seen elsewhere in the stream: pipe, const, media
  input  wire logic [2:0]  setup_seen,
  // prefetch read requests to graphics memory
  output logic             mem_read,
  output logic [31:0]      mem_address,
  input  wire logic        mem_ready,
  // group validity
  output logic [2:0]       group_valid,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  typedef struct packed {
    sipd_pkg::sipd_state_e st;
    logic [7:0]            skip;
    logic                  pf_en;
    logic                  rd_done;
    logic [31:0]           rdata;
    logic [15:0]           n_inval;
    logic [15:0]           n_pref;
    logic [15:0]           n_unknown;
    logic [31:0]           last_addr;
    logic [2:0]            last_cnt;
  } sipd_s;
  sipd_s q, d;

  logic [2:0]  inval_pulse;
  logic [2:0]  sw_setup;
  logic        iss_start;
  logic        iss_busy;
  logic        iss_abort;
  logic        hdr_gfx;
  logic        hdr_inval;
  logic        hdr_pref;
  logic        take;
  logic        reg_wr;
  logic        reg_rd;

  // header classification of the current stream word
  assign hdr_gfx   = cmd_data[`SIPD_TYPE_HI:`SIPD_TYPE_LO] == `SIPD_TYPE_GFX
                  && cmd_data[`SIPD_OPC_HI:`SIPD_OPC_LO] == `SIPD_OPC_ORDERED;
  assign hdr_inval = hdr_gfx
                  && cmd_data[`SIPD_SUB_HI:`SIPD_SUB_LO] == `SIPD_SUB_ONE_DW
                  && cmd_data[`SIPD_SOPC_HI:`SIPD_SOPC_LO] == `SIPD_SOPC_INVAL;
  assign hdr_pref  = hdr_gfx
                  && cmd_data[`SIPD_SUB_HI:`SIPD_SUB_LO] == `SIPD_SUB_SHARED
                  && cmd_data[`SIPD_SOPC_HI:`SIPD_SOPC_LO] == `SIPD_SOPC_PREF;

  // stream is stalled only while a prefetch is still issuing, keeping order
  assign cmd_ready = q.st != sipd_pkg::SIPD_ISSUE || !iss_busy;
  assign take      = cmd_valid && cmd_ready;

  // invalidate enables act in the cycle the header is taken; reserved bits ignored
  assign inval_pulse = (take && q.st == sipd_pkg::SIPD_IDLE && hdr_inval)
                     ? {cmd_data[`SIPD_INV_PIPE_BIT], cmd_data[`SIPD_INV_CONST_BIT],
                        cmd_data[`SIPD_INV_MEDIA_BIT]} : 3'h0;

  // prefetch launches on the address dword when enabled and some group is valid
  assign iss_start = take && q.st == sipd_pkg::SIPD_DW1 && q.pf_en
                  && (|group_valid);
  // an invalidate leaving no valid group cuts a running prefetch short
  assign iss_abort = ~|group_valid;

  // bus decode: single-cycle answer, write then read one cycle later
  assign reg_wr          = avs_write;
  assign reg_rd          = avs_read && !q.rd_done;
  assign avs_waitrequest = avs_read && !q.rd_done;
  assign avs_readdata    = q.rdata;
  assign sw_setup        = (reg_wr && avs_address[4:2] == `SIPD_REG_SETUP)
                         ? avs_writedata[2:0] : 3'h0;

  // command sequencing and register file
  always_comb begin
    d         = q;
    d.rd_done = reg_rd;
    unique case (q.st)
      sipd_pkg::SIPD_IDLE: begin
        if (take) begin
          if (hdr_inval) begin
            d.n_inval = q.n_inval + 16'h1;
          end else if (hdr_pref) begin
            d.n_pref = q.n_pref + 16'h1;
            d.skip   = cmd_data[`SIPD_LEN_HI:`SIPD_LEN_LO];
            d.st     = sipd_pkg::SIPD_DW1;
          end else begin
            d.n_unknown = q.n_unknown + 16'h1;
          end
        end
      end
      sipd_pkg::SIPD_DW1: begin
        if (take) begin
          d.last_addr = {cmd_data[`SIPD_ADDR_HI:`SIPD_ADDR_LO], 6'h00};
          d.last_cnt  = cmd_data[`SIPD_CNT_HI:`SIPD_CNT_LO];
          d.st        = (cmd_data[`SIPD_LEN_HI:`SIPD_LEN_LO] == 8'h0 && q.skip == 8'h0)
                      ? sipd_pkg::SIPD_ISSUE : sipd_pkg::SIPD_SKIP;
          if (q.skip == 8'h0) begin
            d.st = sipd_pkg::SIPD_ISSUE;
          end
        end
      end
      sipd_pkg::SIPD_SKIP: begin
        if (take) begin
          d.skip = q.skip - 8'h1;
          if (q.skip == 8'h1) begin
            d.st = sipd_pkg::SIPD_ISSUE;
          end
        end
      end
      sipd_pkg::SIPD_ISSUE: begin
        if (!iss_busy) begin
          d.st = sipd_pkg::SIPD_IDLE;
        end
      end
    endcase
    if (reg_wr && avs_address[4:2] == `SIPD_REG_CMD) begin
      d.pf_en = avs_writedata[0];
    end
    if (reg_rd) begin
      unique case (avs_address[4:2])
        `SIPD_REG_CMD:      d.rdata = {31'h0, q.pf_en};
        `SIPD_REG_VALID:    d.rdata = {29'h0, group_valid};
        `SIPD_REG_STATUS:   d.rdata = {q.n_pref, q.n_inval};
        `SIPD_REG_LASTADDR: d.rdata = {q.last_addr[31:6], 3'h0, q.last_cnt};
        default:            d.rdata = {16'h0, q.n_unknown};
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q       <= '0;
      q.st    <= sipd_pkg::SIPD_IDLE;
      q.pf_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // pointer group validity: bit 2 pipe, bit 1 constant, bit 0 media
  sipd_valid_flags #(
    .GROUPS (3)
  ) u_flags (
    .mclk        (mclk),
    .resetn      (resetn),
    .setup_pulse (setup_seen | sw_setup),
    .inval_pulse (inval_pulse),
    .valid       (group_valid)
  );

  // line read issuer
  sipd_line_issuer u_issue (
    .mclk        (mclk),
    .resetn      (resetn),
    .start       (iss_start),
    .start_line  (cmd_data[`SIPD_ADDR_HI:`SIPD_ADDR_LO]),
    .count_m1    (cmd_data[`SIPD_CNT_HI:`SIPD_CNT_LO]),
    .abort       (iss_abort),
    .busy        (iss_busy),
    .mem_read    (mem_read),
    .mem_address (mem_address),
    .mem_ready   (mem_ready)
  );

  // assertions
  sequence s_inval_hdr(int b);
    take && q.st == sipd_pkg::SIPD_IDLE && hdr_inval && cmd_data[b];
  endsequence
  sequence s_pref_addr;
    take && q.st == sipd_pkg::SIPD_DW1 && q.pf_en && (|group_valid) && !iss_busy;
  endsequence

  a_pipe_inval: assert property (@(posedge mclk) disable iff (!resetn)
    s_inval_hdr(2) and (!setup_seen[2] && !sw_setup[2]) |=> !group_valid[2])
    else $error("pipe group stayed valid after invalidate");
  a_const_inval: assert property (@(posedge mclk) disable iff (!resetn)
    s_inval_hdr(1) and (!setup_seen[1] && !sw_setup[1]) |=> !group_valid[1])
    else $error("const group stayed valid after invalidate");
  a_media_inval: assert property (@(posedge mclk) disable iff (!resetn)
    s_inval_hdr(0) and (!setup_seen[0] && !sw_setup[0]) |=> !group_valid[0])
    else $error("media group stayed valid after invalidate");
  a_inval_match: assert property (@(posedge mclk) disable iff (!resetn)
    (|inval_pulse) |-> cmd_data[23:16] == 8'h02 && cmd_data[28:27] == 2'h1)
    else $error("invalidate acted on wrong header");
  a_pref_order: assert property (@(posedge mclk) disable iff (!resetn)
    q.st == sipd_pkg::SIPD_DW1 |-> ($past(take) && $past(hdr_pref)
      && $past(q.st) == sipd_pkg::SIPD_IDLE)
      || ($past(q.st) == sipd_pkg::SIPD_DW1 && !$past(take)))
    else $error("address dword reached without prefetch header");
  a_pref_addr: assert property (@(posedge mclk) disable iff (!resetn)
    s_pref_addr |=> mem_read || !(|group_valid)
      ##0 mem_address == {$past(cmd_data[31:6]), 6'h00})
    else $error("prefetch address not taken as absolute");
  a_pref_none: assert property (@(posedge mclk) disable iff (!resetn)
    !(|group_valid) |-> !mem_read)
    else $error("read issued with no valid group");
  a_pref_span: assert property (@(posedge mclk) disable iff (!resetn)
    (s_pref_addr and (cmd_data[2:0] == 3'h0)) ##1 (mem_read && mem_ready) |=> !mem_read)
    else $error("single-line prefetch issued more than one read");
endmodule // sipd_decoder

//--- sim/sipd_mem_model.sv
// graphics memory side: takes prefetch line reads, may stall them
// assumes: mem_read is held until mem_ready, one mclk domain, no fill data returned
`timescale 1ns/1ps
module sipd_mem_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // stall control from the bench
  input  wire logic slow,
  // line read request
  input  wire logic mem_read,
  output logic      mem_ready
);
  logic ready_q;
  // fast: always ready; slow: at most every other cycle while a read waits
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else if (slow) begin
      ready_q <= mem_read & ~ready_q;
    end else begin
      ready_q <= 1'b1;
    end
  end
  assign mem_ready = ready_q;
endmodule // sipd_mem_model

//--- sim/tb_top.sv
// bench for the state invalidate / prefetch decoder
// assumes: sipd_decoder top, Avalon-MM slave, memory model in sim/
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] cmd_data = 32'h0;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready;
  logic [2:0]  setup_seen = 3'h0;
  logic        mem_read;
  logic [31:0] mem_address;
  logic        mem_ready;
  logic        slow = 1'b0;
  logic [2:0]  group_valid;
  logic [4:0]  avs_address = 5'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] lines[$];
  logic [31:0] rd;
  logic [31:0] bad[4] = '{32'h69000000, 32'h68030000, 32'h60020005, 32'h48020001};
  logic [2:0]  bit_m;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n_inval = 0;

  sipd_decoder i_sipd_decoder (.mclk(mclk), .resetn(resetn), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .setup_seen(setup_seen),
    .mem_read(mem_read), .mem_address(mem_address), .mem_ready(mem_ready),
    .group_valid(group_valid), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  sipd_mem_model i_sipd_mem_model (.mclk(mclk), .resetn(resetn), .slow(slow),
    .mem_read(mem_read), .mem_ready(mem_ready));

  // 125 MHz clock
  always #4 mclk = ~mclk;
  // log every accepted line read, sampled where the signals are settled
  always @(negedge mclk) begin
    if (resetn && mem_read === 1'b1 && mem_ready === 1'b1) lines.push_back(mem_address);
  end
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // group flags compared one full cycle after the cause
  task automatic chk_flags(input logic [2:0] exp);
    @(posedge mclk);
    @(negedge mclk);
    chk({29'h0, group_valid}, {29'h0, exp});
    @(posedge mclk);
  endtask
  // one command word, held until taken; entered just after a rising edge
  task automatic send(input logic [31:0] w);
    cmd_valid <= 1'b1;
    cmd_data <= w;
    do @(negedge mclk); while (cmd_ready !== 1'b1);
    @(posedge mclk);
  endtask
  // drop valid and wait until all line reads have gone out
  task automatic drain();
    cmd_valid <= 1'b0;
    do @(negedge mclk); while (cmd_ready !== 1'b1 || mem_read !== 1'b0);
    @(posedge mclk);
  endtask
  task automatic avs_wr(input logic [4:0] a, input logic [31:0] d);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic avs_rd(input logic [4:0] a, output logic [31:0] d);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pulse_setup(input logic [2:0] m);
    setup_seen <= m;
    @(posedge mclk);
    setup_seen <= 3'h0;
    @(posedge mclk);
  endtask
  // prefetch with len extra dwords; expects n ascending line reads from a
  task automatic pf(input logic [31:0] a, input logic [2:0] c, input logic [7:0] len,
                    input logic s, input int n);
    lines.delete();
    slow <= s;
    send(32'h60030000 | {24'h0, len});
    send(a | {29'h0, c});
    for (int k = 0; k < len; k++) send(32'h0);
    drain();
    chk(lines.size(), n);
    for (int k = 0; k < n && k < lines.size(); k++) chk(lines[k], a + 32'h40 * k);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk({29'h0, group_valid}, 32'h0);
    avs_rd(5'h00, rd);
    chk(rd, 32'h1);
    avs_rd(5'h0c, rd);
    chk(rd, 32'h0);
    avs_rd(5'h14, rd);
    chk(rd, 32'h0);
    pulse_setup(3'h7);
    chk_flags(3'h7);
    pf(32'h00001000, 3'h0, 8'h0, 1'b0, 1);
    pf(32'hfedcba40, 3'h7, 8'h1, 1'b1, 8);
    avs_rd(5'h10, rd);
    chk(rd, 32'hfedcba47);
    // each enable alone, then none
    for (int i = 0; i < 4; i++) begin
      bit_m = 3'h1 << i;
      avs_wr(5'h08, 32'h7);
      send(32'h68020000 | {29'h0, bit_m});
      cmd_valid <= 1'b0;
      n_inval++;
      chk_flags(3'h7 & ~bit_m);
    end
    send(32'h68020007);
    cmd_valid <= 1'b0;
    n_inval++;
    chk_flags(3'h0);
    pf(32'h00002000, 3'h3, 8'h0, 1'b0, 0);
    pulse_setup(3'h4);
    chk_flags(3'h4);
    pf(32'h00002000, 3'h3, 8'h0, 1'b0, 4);
    avs_wr(5'h00, 32'h0);
    pf(32'h00003000, 3'h1, 8'h0, 1'b0, 0);
    avs_wr(5'h00, 32'h1);
    avs_wr(5'h04, 32'h0);
    chk_flags(3'h4);
    // near-miss headers are dropped as single unknown words
    lines.delete();
    for (int i = 0; i < 4; i++) send(bad[i]);
    drain();
    chk(lines.size(), 0);
    chk_flags(3'h4);
    avs_rd(5'h14, rd);
    chk(rd & 32'hffff, 32'h4);
    avs_rd(5'h0c, rd);
    chk(rd & 32'hffff, n_inval);
    report_and_stop();
  end
endmodule // tb_top
